// File: out_term_pkg.sv
// constants, codes and the status carrier for the output terminal selector
// assumes one 250 MHz clock shared with the drive control core
package out_term_pkg;

   // register port geometry
   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;
   localparam int SEL_W = 6;
   localparam int VAL_W = 16;
   localparam int TIME_W = 32;
   localparam int MAX_TERM = 8;

   // register offsets (word index on the plain port)
   localparam logic [4:0] OFS_SEL_BASE = 5'h00;
   localparam logic [4:0] OFS_RUN_TIME_THR = 5'h08;
   localparam logic [4:0] OFS_PWR_ON_THR = 5'h09;
   localparam logic [4:0] OFS_CUR_RUN_THR = 5'h0a;
   localparam logic [4:0] OFS_TIMER_SET = 5'h0b;
   localparam logic [4:0] OFS_AI_LIMITS = 5'h0c;
   localparam logic [4:0] OFS_TEMP_THR = 5'h0d;
   localparam logic [4:0] OFS_CTRL = 5'h0e;
   localparam logic [4:0] OFS_STATUS = 5'h0f;

   // field positions
   localparam int CTRL_TIMING_EN_BIT = 0;
   localparam int CTRL_COMM_LSB = 8;
   localparam int STAT_PULSE_BIT = 8;
   localparam int HI_LSB = 16;

   // values after reset
   localparam logic [5:0] RST_SEL = 6'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // function selection codes
   localparam logic [5:0] CODE_NONE = 6'h00;
   localparam logic [5:0] CODE_PLC_DONE = 6'h0b;
   localparam logic [5:0] CODE_RUN_TIME = 6'h0c;
   localparam logic [5:0] CODE_FREQ_LIMITED = 6'h0d;
   localparam logic [5:0] CODE_TORQUE_LIMITED = 6'h0e;
   localparam logic [5:0] CODE_READY = 6'h0f;
   localparam logic [5:0] CODE_AI_GT = 6'h10;
   localparam logic [5:0] CODE_UPPER_REACHED = 6'h11;
   localparam logic [5:0] CODE_LOWER_NO_STOP = 6'h12;
   localparam logic [5:0] CODE_UNDERVOLT = 6'h13;
   localparam logic [5:0] CODE_COMM = 6'h14;
   localparam logic [5:0] CODE_ZERO_SPEED2 = 6'h17;
   localparam logic [5:0] CODE_PWR_ON_TIME = 6'h18;
   localparam logic [5:0] CODE_TIMING = 6'h1e;
   localparam logic [5:0] CODE_AI_LIMIT = 6'h1f;
   localparam logic [5:0] CODE_LOAD_ZERO = 6'h20;
   localparam logic [5:0] CODE_MODULE_TEMP = 6'h23;
   localparam logic [5:0] CODE_LOWER_AT_STOP = 6'h25;
   localparam logic [5:0] CODE_ALARM = 6'h26;
   localparam logic [5:0] CODE_MOTOR_HOT = 6'h27;
   localparam logic [5:0] CODE_CUR_RUN_TIME = 6'h28;

   // pulse timing
   localparam int PULSE_MS = 250;
   localparam int CLK_KHZ = 250000;
   localparam int PULSE_CYCLES = PULSE_MS * CLK_KHZ;

   // drive state from the control core, same clock domain
   typedef struct packed {
      logic running;
      logic speed_mode;
      logic torque_at_limit;
      logic circuits_stable;
      logic fault_present;
      logic able_to_run;
      logic fault_run_on;
      logic undervoltage;
      logic load_zero;
      logic plc_cycle_done;
      logic [VAL_W-1:0] set_freq;
      logic [VAL_W-1:0] out_freq;
      logic [VAL_W-1:0] upper_freq_limit;
      logic [VAL_W-1:0] lower_freq_limit;
      logic [VAL_W-1:0] first_analog_input;
      logic [VAL_W-1:0] second_analog_input;
      logic [VAL_W-1:0] heatsink_temperature;
      logic [VAL_W-1:0] motor_temperature;
      logic [TIME_W-1:0] accum_run_time;
      logic [TIME_W-1:0] power_on_time_counter;
      logic [TIME_W-1:0] current_run_time;
   } drive_status_s;

endpackage

// File: out_term_select.sv
// digital output terminal function selector with its setting registers
// assumes status flags come from logic on the same clock, registers on a plain port
//
// The address-and-strobe port and the address map were left to the implementer.
module out_term_select #(
   parameter int NUM_TERM = 5,
   parameter int PULSE_CYCLES = out_term_pkg::PULSE_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [out_term_pkg::ADDR_W-1:0] addr_i,
   input wire logic [out_term_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [out_term_pkg::DATA_W-1:0] rdata_o,
   input wire out_term_pkg::drive_status_s status_i,
   output logic [NUM_TERM-1:0] term_o
);

   localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
   localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);

   // refuse settings the logic cannot serve
   if (NUM_TERM < 1 || NUM_TERM > out_term_pkg::MAX_TERM) begin : g_bad_num
      $error("NUM_TERM must be 1 to 8");
   end
   if (PULSE_CYCLES < 1) begin : g_bad_pulse
      $error("PULSE_CYCLES must be at least 1");
   end

   logic [out_term_pkg::SEL_W-1:0] sel_ff [NUM_TERM];
   logic [out_term_pkg::TIME_W-1:0] run_time_thr_ff;
   logic [out_term_pkg::TIME_W-1:0] pwr_on_thr_ff;
   logic [out_term_pkg::TIME_W-1:0] cur_run_thr_ff;
   logic [out_term_pkg::TIME_W-1:0] timer_set_ff;
   logic [out_term_pkg::VAL_W-1:0] ai_upper_ff;
   logic [out_term_pkg::VAL_W-1:0] ai_lower_ff;
   logic [out_term_pkg::VAL_W-1:0] module_temp_thr_ff;
   logic [out_term_pkg::VAL_W-1:0] motor_hot_thr_ff;
   logic timing_en_ff;
   logic [NUM_TERM-1:0] comm_out_ff;
   logic [out_term_pkg::DATA_W-1:0] rdata_ff;
   logic [out_term_pkg::DATA_W-1:0] nxt_rdata;
   logic [NUM_TERM-1:0] term_ff;
   logic pulse_ff;
   logic [CNT_W-1:0] pulse_cnt_ff;
   logic wr_sel;
   logic wr_run;
   logic wr_pwr;
   logic wr_cur;
   logic wr_tmr;
   logic wr_ai;
   logic wr_temp;
   logic wr_ctrl;

   // write decode for the shared settings and the per-terminal selection codes
   assign wr_run = wr_i && (addr_i == out_term_pkg::OFS_RUN_TIME_THR);
   assign wr_pwr = wr_i && (addr_i == out_term_pkg::OFS_PWR_ON_THR);
   assign wr_cur = wr_i && (addr_i == out_term_pkg::OFS_CUR_RUN_THR);
   assign wr_tmr = wr_i && (addr_i == out_term_pkg::OFS_TIMER_SET);
   assign wr_ai = wr_i && (addr_i == out_term_pkg::OFS_AI_LIMITS);
   assign wr_temp = wr_i && (addr_i == out_term_pkg::OFS_TEMP_THR);
   assign wr_ctrl = wr_i && (addr_i == out_term_pkg::OFS_CTRL);
   assign wr_sel = wr_i && (addr_i < out_term_pkg::ADDR_W'(NUM_TERM));

   // time thresholds
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_time_thr_ff <= out_term_pkg::RST_WORD;
         pwr_on_thr_ff <= out_term_pkg::RST_WORD;
         cur_run_thr_ff <= out_term_pkg::RST_WORD;
         timer_set_ff <= out_term_pkg::RST_WORD;
      end else begin
         if (wr_run) begin
            run_time_thr_ff <= wdata_i;
         end
         if (wr_pwr) begin
            pwr_on_thr_ff <= wdata_i;
         end
         if (wr_cur) begin
            cur_run_thr_ff <= wdata_i;
         end
         if (wr_tmr) begin
            timer_set_ff <= wdata_i;
         end
      end
   end

   // analog window and temperature thresholds
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ai_lower_ff <= out_term_pkg::RST_WORD[out_term_pkg::VAL_W-1:0];
         ai_upper_ff <= out_term_pkg::RST_WORD[out_term_pkg::VAL_W-1:0];
         module_temp_thr_ff <= out_term_pkg::RST_WORD[out_term_pkg::VAL_W-1:0];
         motor_hot_thr_ff <= out_term_pkg::RST_WORD[out_term_pkg::VAL_W-1:0];
      end else begin
         if (wr_ai) begin
            ai_lower_ff <= wdata_i[out_term_pkg::VAL_W-1:0];
            ai_upper_ff <= wdata_i[out_term_pkg::HI_LSB +: out_term_pkg::VAL_W];
         end
         if (wr_temp) begin
            module_temp_thr_ff <= wdata_i[out_term_pkg::VAL_W-1:0];
            motor_hot_thr_ff <= wdata_i[out_term_pkg::HI_LSB +: out_term_pkg::VAL_W];
         end
      end
   end

   // control word: timing enable and serially commanded terminal states
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timing_en_ff <= 1'b0;
         comm_out_ff <= '0;
      end else if (wr_ctrl) begin
         timing_en_ff <= wdata_i[out_term_pkg::CTRL_TIMING_EN_BIT];
         comm_out_ff <= wdata_i[out_term_pkg::CTRL_COMM_LSB +: NUM_TERM];
      end
   end

   // read mux, answer stands only in the cycle after the strobe
   always_comb begin
      nxt_rdata = '0;
      if (rd_i) begin
         if (addr_i < out_term_pkg::ADDR_W'(NUM_TERM)) begin
            nxt_rdata = {26'h000_0000, sel_ff[addr_i[2:0]]};
         end else begin
            case (addr_i)
               out_term_pkg::OFS_RUN_TIME_THR: nxt_rdata = run_time_thr_ff;
               out_term_pkg::OFS_PWR_ON_THR: nxt_rdata = pwr_on_thr_ff;
               out_term_pkg::OFS_CUR_RUN_THR: nxt_rdata = cur_run_thr_ff;
               out_term_pkg::OFS_TIMER_SET: nxt_rdata = timer_set_ff;
               out_term_pkg::OFS_AI_LIMITS: nxt_rdata = {ai_upper_ff, ai_lower_ff};
               out_term_pkg::OFS_TEMP_THR: nxt_rdata = {motor_hot_thr_ff, module_temp_thr_ff};
               out_term_pkg::OFS_CTRL: begin
                  nxt_rdata[out_term_pkg::CTRL_TIMING_EN_BIT] = timing_en_ff;
                  nxt_rdata[out_term_pkg::CTRL_COMM_LSB +: NUM_TERM] = comm_out_ff;
               end
               out_term_pkg::OFS_STATUS: begin
                  nxt_rdata[NUM_TERM-1:0] = term_ff;
                  nxt_rdata[out_term_pkg::STAT_PULSE_BIT] = pulse_ff;
               end
               default: nxt_rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_ff <= out_term_pkg::RST_WORD;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o = rdata_ff;

   // program cycle pulse: a new cycle end restarts the full width
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pulse_ff <= 1'b0;
         pulse_cnt_ff <= '0;
      end else if (status_i.plc_cycle_done) begin
         pulse_ff <= 1'b1;
         pulse_cnt_ff <= '0;
      end else if (pulse_ff) begin
         if (pulse_cnt_ff == PULSE_LAST) begin
            pulse_ff <= 1'b0;
            pulse_cnt_ff <= '0;
         end else begin
            pulse_cnt_ff <= pulse_cnt_ff + CNT_W'(1);
         end
      end
   end

   // one selector and one output flop per terminal
   for (genvar gi = 0; gi < NUM_TERM; gi++) begin : g_term
      logic cond;

      // selection code register of this terminal
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            sel_ff[gi] <= out_term_pkg::RST_SEL;
         end else if (wr_sel && (addr_i[2:0] == 3'(gi))) begin
            sel_ff[gi] <= wdata_i[out_term_pkg::SEL_W-1:0];
         end
      end

      // condition chosen by the code
      always_comb begin
         case (sel_ff[gi])
            out_term_pkg::CODE_PLC_DONE: cond = pulse_ff;
            out_term_pkg::CODE_RUN_TIME:
               cond = status_i.accum_run_time > run_time_thr_ff;
            out_term_pkg::CODE_FREQ_LIMITED:
               cond = ((status_i.set_freq > status_i.upper_freq_limit)
                       && (status_i.out_freq >= status_i.upper_freq_limit))
                      || ((status_i.set_freq < status_i.lower_freq_limit)
                       && (status_i.out_freq <= status_i.lower_freq_limit));
            out_term_pkg::CODE_TORQUE_LIMITED:
               cond = status_i.speed_mode && status_i.torque_at_limit;
            out_term_pkg::CODE_READY:
               cond = status_i.circuits_stable && !status_i.fault_present
                      && status_i.able_to_run;
            out_term_pkg::CODE_AI_GT:
               cond = status_i.first_analog_input > status_i.second_analog_input;
            out_term_pkg::CODE_UPPER_REACHED:
               cond = status_i.out_freq == status_i.upper_freq_limit;
            out_term_pkg::CODE_LOWER_NO_STOP:
               cond = status_i.running
                      && (status_i.out_freq <= status_i.lower_freq_limit);
            out_term_pkg::CODE_LOWER_AT_STOP:
               cond = !status_i.running
                      || (status_i.out_freq <= status_i.lower_freq_limit);
            out_term_pkg::CODE_UNDERVOLT: cond = status_i.undervoltage;
            out_term_pkg::CODE_COMM: cond = comm_out_ff[gi];
            out_term_pkg::CODE_ZERO_SPEED2:
               cond = status_i.out_freq == '0;
            out_term_pkg::CODE_PWR_ON_TIME:
               cond = status_i.power_on_time_counter > pwr_on_thr_ff;
            out_term_pkg::CODE_TIMING:
               cond = timing_en_ff && (status_i.current_run_time >= timer_set_ff);
            out_term_pkg::CODE_AI_LIMIT:
               cond = (status_i.first_analog_input > ai_upper_ff)
                      || (status_i.first_analog_input < ai_lower_ff);
            out_term_pkg::CODE_LOAD_ZERO: cond = status_i.load_zero;
            out_term_pkg::CODE_MODULE_TEMP:
               cond = status_i.heatsink_temperature >= module_temp_thr_ff;
            out_term_pkg::CODE_ALARM:
               cond = status_i.fault_run_on && status_i.running;
            out_term_pkg::CODE_MOTOR_HOT:
               cond = status_i.motor_temperature >= motor_hot_thr_ff;
            out_term_pkg::CODE_CUR_RUN_TIME:
               cond = status_i.current_run_time > cur_run_thr_ff;
            default: cond = 1'b0;
         endcase
      end

      // registered terminal drive
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            term_ff[gi] <= 1'b0;
         end else begin
            term_ff[gi] <= cond;
         end
      end

      property p_zero_code_idle;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_NONE) |=> !term_ff[gi];
      endproperty
      a_zero_code_idle: assert property (p_zero_code_idle)
         else $error("terminal active with code zero");

      property p_reserved_idle;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == 6'h15 || sel_ff[gi] > out_term_pkg::CODE_CUR_RUN_TIME)
            |=> !term_ff[gi];
      endproperty
      a_reserved_idle: assert property (p_reserved_idle)
         else $error("terminal active with reserved code");

      property p_pulse_follow;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_PLC_DONE) |=> (term_ff[gi] == $past(pulse_ff));
      endproperty
      a_pulse_follow: assert property (p_pulse_follow)
         else $error("pulse terminal does not follow pulse");

      property p_comm_follow;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_COMM) ##1 $stable(sel_ff[gi])
            |-> (term_ff[gi] == $past(comm_out_ff[gi]));
      endproperty
      a_comm_follow: assert property (p_comm_follow)
         else $error("commanded terminal mismatch");

      property p_undervolt;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_UNDERVOLT) && status_i.undervoltage
            |=> term_ff[gi];
      endproperty
      a_undervolt: assert property (p_undervolt)
         else $error("undervoltage not shown");

      property p_lower_stop;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_LOWER_NO_STOP) && !status_i.running
            |=> !term_ff[gi];
      endproperty
      a_lower_stop: assert property (p_lower_stop)
         else $error("lower limit output while stopped");

      property p_ai_gt;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_AI_GT)
            |=> (term_ff[gi] == $past(status_i.first_analog_input
                                      > status_i.second_analog_input));
      endproperty
      a_ai_gt: assert property (p_ai_gt)
         else $error("input comparison output wrong");

      property p_ready;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_READY)
            |=> (term_ff[gi] == $past(status_i.circuits_stable && !status_i.fault_present
                                      && status_i.able_to_run));
      endproperty
      a_ready: assert property (p_ready)
         else $error("ready output wrong");

      property p_torque_mode;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_TORQUE_LIMITED) && !status_i.speed_mode
            |=> !term_ff[gi];
      endproperty
      a_torque_mode: assert property (p_torque_mode)
         else $error("torque output outside speed mode");

      property p_zero_speed;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_ZERO_SPEED2) && (status_i.out_freq == '0)
            |=> term_ff[gi];
      endproperty
      a_zero_speed: assert property (p_zero_speed)
         else $error("zero speed not shown");

      property p_alarm;
         @(posedge ref_clk_i) disable iff (!rst_b_i)
         (sel_ff[gi] == out_term_pkg::CODE_ALARM)
            |=> (term_ff[gi] == $past(status_i.fault_run_on && status_i.running));
      endproperty
      a_alarm: assert property (p_alarm)
         else $error("alarm output wrong");
   end

   assign term_o = term_ff;

   // pulse counter never passes its terminal count
   property p_pulse_bound;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      pulse_cnt_ff <= PULSE_LAST;
   endproperty
   a_pulse_bound: assert property (p_pulse_bound)
      else $error("pulse counter overran");

   // a cycle end starts the pulse, which ends only at the terminal count
   property p_pulse_end;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      $fell(pulse_ff) |-> ($past(pulse_cnt_ff) == PULSE_LAST)
                          && !$past(status_i.plc_cycle_done);
   endproperty
   a_pulse_end: assert property (p_pulse_end)
      else $error("pulse ended early");

   property p_pulse_start;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      status_i.plc_cycle_done |=> pulse_ff && (pulse_cnt_ff == '0);
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("pulse not started");

endmodule

// File: out_term_load.sv
// load model for the selector's digital output terminals
// assumes active-high terminal levels that close the contact or transistor
module out_term_load #(
   parameter int NUM_TERM = 5
) (
   input wire logic [NUM_TERM-1:0] term_i,
   output logic [NUM_TERM-1:0] load_on_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // contact or transistor conducts while its terminal is on
   assign load_on_o = term_i;
endmodule

// File: out_term_select_test.sv
// self-checking bench for the output terminal selector
// assumes the selector and the load model are compiled before this file
module out_term_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NT = 5;
   localparam int PW = 8;
   typedef struct packed {logic is_rd; logic [31:0] val;} note_s;
   logic ref_clk;
   logic rst_b = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [NT-1:0] term;
   logic [NT-1:0] load_on;
   out_term_pkg::drive_status_s st = '0;
   note_s notes[$];
   note_s cur;
   int n_errors = 0;
   int cmp_count = 0;
   logic [31:0] rg[16];
   logic [5:0] code[NT];

   out_term_select #(.NUM_TERM(NT), .PULSE_CYCLES(PW)) u_dut (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .status_i(st), .term_o(term));
   out_term_load #(.NUM_TERM(NT)) u_load (.term_i(term), .load_on_o(load_on));

   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // monitor: oldest note against read data or load state
   always @(negedge ref_clk) begin
      if (notes.size() > 0) begin
         cur = notes.pop_front();
         check(cur.is_rd ? rdata : {27'h0, load_on}, cur.val);
      end
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      report_and_stop();
   end

   task automatic do_reset();
      @(posedge ref_clk);
      rst_b <= 1'b0;
      st <= '0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      foreach (rg[a]) rg[a] = 32'h0;
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      notes.push_back('{1'b1, e});
   endtask

   // expected terminal level from the selection code and drive state
   function automatic logic ref_term(input logic [5:0] c, input out_term_pkg::drive_status_s s,
                                     input int i);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = rg[12][15:0];
      hi = rg[12][31:16];
      case (c)
         6'h0c: return s.accum_run_time > rg[8];
         6'h0d: return (s.set_freq > s.upper_freq_limit && s.out_freq >= s.upper_freq_limit) ||
                       (s.set_freq < s.lower_freq_limit && s.out_freq <= s.lower_freq_limit);
         6'h0e: return s.speed_mode && s.torque_at_limit;
         6'h0f: return s.circuits_stable && !s.fault_present && s.able_to_run;
         6'h10: return s.first_analog_input > s.second_analog_input;
         6'h11: return s.out_freq == s.upper_freq_limit;
         6'h12: return s.running && s.out_freq <= s.lower_freq_limit;
         6'h25: return !s.running || s.out_freq <= s.lower_freq_limit;
         6'h13: return s.undervoltage;
         6'h14: return rg[14][8+i];
         6'h17: return s.out_freq == 16'h0;
         6'h18: return s.power_on_time_counter > rg[9];
         6'h1e: return rg[14][0] && s.current_run_time >= rg[11];
         6'h1f: return s.first_analog_input > hi || s.first_analog_input < lo;
         6'h20: return s.load_zero;
         6'h23: return s.heatsink_temperature >= rg[13][15:0];
         6'h26: return s.fault_run_on && s.running;
         6'h27: return s.motor_temperature >= rg[13][31:16];
         6'h28: return s.current_run_time > rg[10];
         default: return 1'b0;
      endcase
   endfunction

   // random codes, settings and drive state, then terminals and readback
   task automatic rand_round();
      logic [31:0] d;
      logic [NT-1:0] e;
      out_term_pkg::drive_status_s s;
      for (int i = 0; i < NT; i++) begin
         code[i] = $urandom_range(0, 1) ? 6'($urandom_range(11, 40)) : 6'($urandom_range(0, 63));
         rg[i] = {26'h0, code[i]};
         wr_reg(5'(i), rg[i]);
      end
      for (int a = 8; a < 14; a++) begin
         d = $urandom_range(0, 3);
         if (a >= 12)
            d = d | ($urandom_range(0, 3) << 16);
         rg[a] = d;
         wr_reg(5'(a), d);
      end
      rg[14] = ($urandom_range(0, 31) << 8) | $urandom_range(0, 1);
      wr_reg(5'h0e, rg[14]);
      s = '0;
      {s.running, s.speed_mode, s.torque_at_limit, s.circuits_stable, s.fault_present,
       s.able_to_run, s.fault_run_on, s.undervoltage, s.load_zero} = 9'($urandom);
      s.set_freq = 16'($urandom_range(0, 3));
      s.out_freq = 16'($urandom_range(0, 3));
      s.upper_freq_limit = 16'($urandom_range(0, 3));
      s.lower_freq_limit = 16'($urandom_range(0, 3));
      s.first_analog_input = 16'($urandom_range(0, 3));
      s.second_analog_input = 16'($urandom_range(0, 3));
      s.heatsink_temperature = 16'($urandom_range(0, 3));
      s.motor_temperature = 16'($urandom_range(0, 3));
      s.accum_run_time = $urandom_range(0, 3);
      s.power_on_time_counter = $urandom_range(0, 3);
      s.current_run_time = $urandom_range(0, 3);
      @(posedge ref_clk);
      st <= s;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < NT; i++) e[i] = ref_term(code[i], s, i);
      notes.push_back('{1'b0, {27'h0, e}});
      rd_reg(5'h0c, rg[12]);
      rd_reg(5'h0e, rg[14]);
      rd_reg(5'h00, rg[0]);
      rd_reg(5'h0f, {27'h0, e});
   endtask

   initial begin
      void'($urandom(27639));
      do_reset();
      // reset values, read-only and unmapped places
      wr_reg(5'h05, 32'hffff_ffff);
      wr_reg(5'h0f, 32'hffff_ffff);
      wr_reg(5'h10, 32'hffff_ffff);
      for (int a = 0; a < 17; a++) rd_reg(5'(a), 32'h0);
      $display("test reset_values done");
      // one program-cycle pulse, counted cycle by cycle
      wr_reg(5'h00, 32'h0000_000b);
      @(posedge ref_clk);
      st.plc_cycle_done <= 1'b1;
      @(posedge ref_clk);
      st.plc_cycle_done <= 1'b0;
      for (int k = 1; k <= PW + 2; k++) begin
         notes.push_back('{1'b0, {31'h0, 1'(k >= 2 && k <= PW + 1)}});
         @(posedge ref_clk);
      end
      // a second cycle end inside the pulse restarts the full width
      @(posedge ref_clk);
      st.plc_cycle_done <= 1'b1;
      @(posedge ref_clk);
      st.plc_cycle_done <= 1'b0;
      repeat (4) @(posedge ref_clk);
      st.plc_cycle_done <= 1'b1;
      @(posedge ref_clk);
      st.plc_cycle_done <= 1'b0;
      rd_reg(5'h0f, 32'h0000_0101);
      repeat (PW - 2) @(posedge ref_clk);
      notes.push_back('{1'b0, 32'h0000_0001});
      @(posedge ref_clk);
      notes.push_back('{1'b0, 32'h0000_0000});
      $display("test pulse_width done");
      for (int r = 0; r < 200; r++) rand_round();
      $display("test random_codes done");
      do_reset();
      for (int a = 0; a < 16; a++) rd_reg(5'(a), 32'h0);
      $display("test second_reset done");
      repeat (2) @(posedge ref_clk);
      if (notes.size() != 0)
         n_errors++;
      report_and_stop();
   end
endmodule
